// ### design/pfr_core.sv
// Power fail response: outage classification, held outputs, reset sequence, pressure trip.
// Assumes power_ok, reset contact and pressure trip are pins; run inputs come from same-clock logic.
`timescale 1ns/1ps
`include "pfr_map.svh"
module pfr_core
  import pfr_pkg::*;
#(
  // Cycles per millisecond tick; a bench may shorten it
  parameter int unsigned MS_CYCLES = `PFR_MS_CYCLES
)
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // Pins
  input wire logic power_ok_in,
  input wire logic reset_contact_in,
  input wire logic pressure_rise_in,
  // Configuration
  input wire logic two_second_outage_option_in,
  input wire logic [2:0] remote_signal_mode_in,
  // Run state from the drive controller
  input wire logic normal_speed_in,
  input wire logic accelerating_in,
  input wire logic braking_in,
  input wire logic remote_in,
  input wire logic warning_in,
  input wire logic start_in,
  // Indicators and commands
  output logic normal_lamp_out,
  output logic alarm_lamp_out,
  output logic buzzer_out,
  output logic decelerate_out,
  output logic brake_cmd_out,
  output logic start_cmd_out,
  // Relay contacts (make side; mode bits can turn remote, alarm and warning into break contacts)
  output logic normal_relay_out,
  output logic accel_relay_out,
  output logic brake_relay_out,
  output logic remote_relay_out,
  output logic alarm_relay_out,
  output logic warning_relay_out
);
  typedef struct packed {
    pfr_state_t state;
    logic [`PFR_TICK_W-1:0] tick;
    logic [`PFR_MS_CNT_W-1:0] ms;
    logic normal;
    logic accel;
    logic brake;
    logic remote;
    logic alarm;
    logic buzzer;
    logic trip;
    logic decel;
  } pfr_core_t;
  pfr_core_t st, next_st;

  logic pwr_lvl;
  logic rst_press;
  logic prs_lvl;

  // Power reads absent just after reset; that brief outage is harmless
  pfr_sync u_pwr (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .pin_in(power_ok_in),
    .level_out(pwr_lvl),
    .rise_out()
  );

  pfr_sync u_rst (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .pin_in(reset_contact_in),
    .level_out(),
    .rise_out(rst_press)
  );

  pfr_sync u_prs (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .pin_in(pressure_rise_in),
    .level_out(prs_lvl),
    .rise_out()
  );

  // Limit in milliseconds for a short outage
  function automatic logic [`PFR_MS_CNT_W-1:0] short_limit(input logic two_sec);
    short_limit = two_sec ? `PFR_MS_CNT_W'(`PFR_LONG_OPT_MS) : `PFR_MS_CNT_W'(`PFR_SHORT_MS);
  endfunction : short_limit

  // Mode bit set turns the make contact into a break contact
  function automatic logic relay_level(input logic active, input logic invert);
    relay_level = active ^ invert;
  endfunction : relay_level

  logic ms_pulse;
  assign ms_pulse = (st.tick == `PFR_TICK_W'(MS_CYCLES - 1));

  // Compared before the increment so the count never wraps
  logic limit_hit;
  assign limit_hit = ms_pulse && (st.ms >= short_limit(two_second_outage_option_in) - 1'b1);

  // Run test shared by the trip clear and the start gate
  logic in_run;
  assign in_run = (st.state == PFR_RUN);

  always_comb begin
    next_st = st;
    next_st.tick = ms_pulse ? '0 : st.tick + 1'b1;
    unique case (st.state)
      PFR_RUN: begin
        // Snapshot follows the drive until power is lost
        next_st.normal = normal_speed_in;
        next_st.accel = accelerating_in;
        next_st.brake = braking_in;
        next_st.remote = remote_in;
        next_st.ms = '0;
        if (!pwr_lvl) begin
          next_st.state = PFR_SHORT;
          next_st.tick = '0;
          next_st.decel = 1'b1;
        end
      end
      PFR_SHORT: begin
        // Snapshot stays frozen while power is out
        if (pwr_lvl) begin
          next_st.state = PFR_RUN;
          next_st.decel = 1'b0;
        end else if (limit_hit) begin
          next_st.state = PFR_LONG;
          next_st.normal = 1'b0;
          next_st.accel = 1'b0;
          next_st.brake = 1'b0;
          next_st.alarm = 1'b1;
          next_st.buzzer = 1'b1;
        end else if (ms_pulse) begin
          next_st.ms = st.ms + 1'b1;
        end
      end
      PFR_LONG: begin
        // Deceleration continues through power return
        // A press while power is out only silences the buzzer
        if (rst_press) begin
          next_st.buzzer = 1'b0;
        end
        if (pwr_lvl) begin
          next_st.state = st.buzzer && !rst_press ? PFR_LONG_RESTORED : PFR_BUZZ_CLEARED;
        end
      end
      PFR_LONG_RESTORED: begin
        if (rst_press) begin
          next_st.buzzer = 1'b0;
          next_st.state = PFR_BUZZ_CLEARED;
        end else if (!pwr_lvl) begin
          // A second outage reopens the remote contact
          next_st.state = PFR_LONG;
        end
      end
      PFR_BUZZ_CLEARED: begin
        // Start is only honoured after the alarm is cleared
        if (rst_press && pwr_lvl) begin
          next_st.alarm = 1'b0;
          next_st.decel = 1'b0;
          next_st.state = PFR_RUN;
        end else if (!pwr_lvl) begin
          // Power lost again before the alarm cleared
          next_st.state = PFR_LONG;
        end
      end
      default: begin
        next_st.state = PFR_RUN;
      end
    endcase

    // Pressure trip latches braking and alarm until a reset press in run with the pressure pin low
    if (prs_lvl) begin
      next_st.trip = 1'b1;
    end else if (rst_press && in_run) begin
      next_st.trip = 1'b0;
    end
  end

  // Synchronous reset returns every flag to idle together
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  logic alarm_any;
  assign alarm_any = st.alarm | st.trip;

  assign normal_lamp_out = st.normal;
  assign alarm_lamp_out = alarm_any;
  assign buzzer_out = st.buzzer;
  assign decelerate_out = st.decel;
  assign brake_cmd_out = st.trip;
  // Gated combinationally so a start never passes a standing alarm
  assign start_cmd_out = start_in && in_run && !alarm_any;
  assign normal_relay_out = st.normal;
  assign accel_relay_out = st.accel;
  assign brake_relay_out = st.brake | st.trip;
  // Long outage opens remote contact, returns after power
  assign remote_relay_out = relay_level((st.state == PFR_LONG) ? 1'b0 : st.remote,
    remote_signal_mode_in[`PFR_MODE_REMOTE]);
  assign alarm_relay_out = relay_level(alarm_any, remote_signal_mode_in[`PFR_MODE_ALARM]);
  assign warning_relay_out = relay_level(warning_in, remote_signal_mode_in[`PFR_MODE_WARNING]);
endmodule : pfr_core

// ### shared/pfr_map.svh
// Constants for the power fail response block: timing counts and config bit positions.
// Assumes a 100 MHz clock; included by bare name.
`ifndef PFR_MAP_SVH
`define PFR_MAP_SVH
`define PFR_CLK_HZ 100000000
`define PFR_SHORT_MS 1000
`define PFR_LONG_OPT_MS 2000
`define PFR_MS_CYCLES (`PFR_CLK_HZ / 1000)
`define PFR_TICK_W 17
`define PFR_MS_CNT_W 12
`define PFR_MODE_ALARM 0
`define PFR_MODE_WARNING 1
`define PFR_MODE_REMOTE 2
`endif

// ### shared/pfr_pkg.sv
// Types for the power fail response block.
// Assumes pfr_map.svh is available on the include path.
package pfr_pkg;
  typedef enum logic [2:0] {
    PFR_RUN = 3'b000,
    PFR_SHORT = 3'b001,
    PFR_LONG = 3'b011,
    PFR_LONG_RESTORED = 3'b010,
    PFR_BUZZ_CLEARED = 3'b110
  } pfr_state_t;
endpackage : pfr_pkg

// ### design/pfr_sync.sv
// Three-flop input conditioner for a pin with single-pulse rise detection.
// Assumes the pin is asynchronous to ref_clk_in.
`timescale 1ns/1ps
module pfr_sync (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // Pin and conditioned outputs
  input wire logic pin_in,
  output logic level_out,
  output logic rise_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic rise;
  } pfr_sync_t;
  pfr_sync_t st, next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = pin_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.rise = 1'b0;
    // Change accepted only when second and third stages agree
    if (st.s2 == st.s3 && st.s3 != st.lvl) begin
      next_st.lvl = st.s3;
      next_st.rise = st.s3;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level_out = st.lvl;
  assign rise_out = st.rise;
endmodule : pfr_sync

// ### tb/pfr_core_assertions.sv
// Port checker for pfr_core.
// Assumes one clock and a synchronous reset.
`timescale 1ns/1ps
module pfr_core_chk (
  input wire logic ref_clk_in, reset_in, power_ok_in, pressure_rise_in, start_in, warning_in,
  input wire logic [2:0] remote_signal_mode_in,
  input wire logic alarm_lamp_out, buzzer_out, decelerate_out, brake_cmd_out, start_cmd_out,
  input wire logic normal_lamp_out, alarm_relay_out, warning_relay_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  sequence s_outage;
    $fell(power_ok_in) ##1 !power_ok_in [*7];
  endsequence
  sequence s_trip;
    $rose(pressure_rise_in) ##1 pressure_rise_in [*5];
  endsequence
  a_outage_decel: assert property (s_outage |-> decelerate_out)
    else $error("decelerate missing after outage");
  a_trip_brake: assert property (s_trip |-> brake_cmd_out && alarm_lamp_out)
    else $error("pressure trip not acted on");
  a_hold_normal: assert property (decelerate_out && $past(decelerate_out) && !alarm_lamp_out
    |-> $stable(normal_lamp_out)) else $error("normal lamp moved in outage");
  a_long_entry: assert property ($rose(buzzer_out) |-> alarm_lamp_out && !normal_lamp_out)
    else $error("long outage left normal lamp or alarm wrong");
  a_buzz_alarm: assert property (buzzer_out |-> alarm_lamp_out)
    else $error("buzzer without alarm");
  a_start_block: assert property (alarm_lamp_out |-> !start_cmd_out)
    else $error("start passed during alarm");
  a_start_pass: assert property (power_ok_in [*8] ##0 (start_in && !alarm_lamp_out && !decelerate_out)
    |-> start_cmd_out) else $error("start refused in run");
  a_alarm_pol: assert property (alarm_relay_out == (alarm_lamp_out ^ remote_signal_mode_in[0]))
    else $error("alarm relay polarity");
  a_warn_pol: assert property (warning_relay_out == (warning_in ^ remote_signal_mode_in[1]))
    else $error("warning relay polarity");
endmodule : pfr_core_chk

bind pfr_core pfr_core_chk u_chk (.*);

// ### tb/pfr_panel.sv
// Front-panel reset switch model.
// Assumes press_in is a one-cycle request.
`timescale 1ns/1ps
module pfr_panel (
  input wire logic ref_clk_in,
  input wire logic press_in,
  output logic contact_out
);
  int unsigned cnt = 0;
  initial contact_out = 1'b0;
  // Open spell after each closure, so one press gives one edge
  always @(posedge ref_clk_in) begin
    if (cnt != 0) cnt <= cnt - 1;
    else if (press_in) cnt <= 20;
    contact_out <= (cnt > 10);
  end
endmodule : pfr_panel

// ### tb/power_fail_response_test.sv
// Testbench for pfr_core.
// Millisecond tick cut to five cycles so long outages fit the run.
`timescale 1ns/1ps
module power_fail_response_test;
  logic ref_clk_in = 0, reset_in = 1, power_ok_in = 1, pressure_rise_in = 0;
  logic two_second_outage_option_in = 0, normal_speed_in = 0, accelerating_in = 0, braking_in = 0;
  logic remote_in = 0, warning_in = 0, start_in = 0, press = 0, reset_contact_in;
  logic [2:0] remote_signal_mode_in = 3'h0;
  logic normal_lamp_out, alarm_lamp_out, buzzer_out, decelerate_out, brake_cmd_out, start_cmd_out;
  logic normal_relay_out, accel_relay_out, brake_relay_out, remote_relay_out, alarm_relay_out;
  logic warning_relay_out;
  int errors = 0, num_checks = 0;
  always #5 ref_clk_in = ~ref_clk_in;
  pfr_core #(.MS_CYCLES(5)) dut (.*);
  pfr_panel panel (.ref_clk_in(ref_clk_in), .press_in(press), .contact_out(reset_contact_in));
  task automatic check(string name, logic got, logic exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask : check
  task automatic cyc(int n);
    repeat (n) @(negedge ref_clk_in);
  endtask : cyc
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic push;
    press = 1; cyc(1); press = 0; cyc(40);
  endtask : push
  task automatic t_short;
    normal_speed_in = 1; remote_in = 1; braking_in = 1; accelerating_in = 1; cyc(10);
    power_ok_in = 0; cyc(20);
    check("decelerate", decelerate_out, 1);
    normal_speed_in = 0; remote_in = 0; braking_in = 0; accelerating_in = 0; cyc(5);
    check("accel relay", accel_relay_out, 1);
    check("normal lamp", normal_lamp_out, 1);
    check("remote relay", remote_relay_out, 1);
    check("brake relay", brake_relay_out, 1);
    power_ok_in = 1; normal_speed_in = 1; remote_in = 1; cyc(20);
    check("decelerate off", decelerate_out, 0);
    check("normal relay", normal_relay_out, 1);
  endtask : t_short
  task automatic t_trip;
    start_in = 1; pressure_rise_in = 1; cyc(10);
    check("brake", brake_cmd_out, 1);
    check("alarm lamp", alarm_lamp_out, 1);
    check("start blocked", start_cmd_out, 0);
    pressure_rise_in = 0; cyc(10);
    check("trip stands", brake_cmd_out, 1);
    push();
    check("trip cleared", brake_cmd_out, 0);
    check("start", start_cmd_out, 1);
    start_in = 0;
  endtask : t_trip
  task automatic t_limit;
    power_ok_in = 0; cyc(4900);
    check("short 1s alarm", alarm_lamp_out, 0);
    power_ok_in = 1; cyc(20);
    check("short 1s decel", decelerate_out, 0);
    two_second_outage_option_in = 1; power_ok_in = 0; cyc(7500);
    check("short 2s alarm", alarm_lamp_out, 0);
    check("short 2s decel", decelerate_out, 1);
    power_ok_in = 1; cyc(20);
    check("short 2s buzzer", buzzer_out, 0);
    check("short 2s end", decelerate_out, 0);
    two_second_outage_option_in = 0;
  endtask : t_limit
  task automatic t_long;
    power_ok_in = 0; cyc(4900);
    check("not yet long", buzzer_out, 0);
    cyc(200);
    check("long alarm", alarm_lamp_out, 1);
    check("long buzzer", buzzer_out, 1);
    check("long normal", normal_lamp_out, 0);
    check("long remote", remote_relay_out, 0);
    power_ok_in = 1; start_in = 1; cyc(20);
    check("still decel", decelerate_out, 1);
    check("remote back", remote_relay_out, 1);
    check("no start", start_cmd_out, 0);
    push();
    check("buzzer off", buzzer_out, 0);
    check("alarm kept", alarm_relay_out, 1);
    check("one event", decelerate_out, 1);
    push();
    check("alarm off", alarm_relay_out, 0);
    check("decel off", decelerate_out, 0);
    check("restart", start_cmd_out, 1);
    start_in = 0;
  endtask : t_long
  task automatic t_mode;
    warning_in = 1;
    for (int m = 0; m < 8; m++) begin
      remote_signal_mode_in = m[2:0]; cyc(4);
      check("alarm relay", alarm_relay_out, m[0]);
      check("warning relay", warning_relay_out, !m[1]);
      check("remote relay", remote_relay_out, !m[2]);
    end
  endtask : t_mode
  initial begin
    cyc(8); reset_in = 0; cyc(8);
    t_short();
    t_trip();
    t_limit();
    t_long();
    t_mode();
    summarize();
  end
  // Hang guard
  initial begin
    cyc(40000); errors++; summarize();
  end
endmodule : power_fail_response_test
